//--- hw/css_consts.svh
// Constants for the clock source and start-up delay selector
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_SRC_PLL 4'h1
`define CSS_SRC_RC 4'h2
`define CSS_SRC_LP 4'h3
`define CSS_SRC_LFX 4'h4

`define CSS_SHIP_SRC 4'h2
`define CSS_SHIP_SUT 2'h2
`define CSS_SHIP_DIV8 1'b1

`define CSS_MS4_CYC 512
`define CSS_MS64_CYC 8192
`define CSS_CK1K 1024
`define CSS_CK16K 16384
`define CSS_CK32K 32768
`define CSS_CK_RST 16'h000E
`define CSS_CK_WAKE_SHORT 16'h0006
`define CSS_PLL_POST_DIV 4
`define CSS_DIV8_FACTOR 8

`define CSS_REG_CAL 2'h0
`define CSS_REG_PLL 2'h1
`define CSS_REG_STAT 2'h2
`define CSS_PLL_EN_BIT 0
`define CSS_PLL_ON_BIT 1
`define CSS_STAT_DIV8_BIT 6
`define CSS_STAT_RUN_BIT 7
`define CSS_CAL_RESET 8'h00

`endif

//--- hw/css_pkg.sv
// Types shared by the clock source selector
package css_pkg;
   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_RST = 3'b001,
      ST_RUN = 3'b010,
      ST_SLEEP = 3'b011,
      ST_WAKE = 3'b100,
      ST_HALT = 3'b101
   } css_state_t;

   typedef struct packed {
      logic [15:0] wakeCk;
      logic [15:0] wakeMs;
      logic [15:0] rstCk;
      logic [15:0] rstMs;
   } css_delay_t;

   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_time_select;
      logic div8;
      logic bad;
   } css_cfg_t;
endpackage : css_pkg

//--- hw/css_tick_counter.sv
// Down counter advanced by a tick pulse
module css_tick_counter #(
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [W-1:0] loadVal,
   input wire logic tick,
   output logic [W-1:0] remain,
   output logic zero
);
   if (W < 1) begin : g_bad_width
      $error("Counter width must be at least 1");
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         remain <= '0;
      end else if (load) begin
         remain <= loadVal;
      end else if (tick && remain != '0) begin
         remain <= remain - W'(1);
      end
   end

   assign zero = (remain == '0);
endmodule : css_tick_counter

//--- hw/css_cfg_latch.sv
// Captures the configuration bits once after reset and decodes delays
`include "css_consts.svh"
module css_cfg_latch #(
   parameter int MS4 = `CSS_MS4_CYC,
   parameter int MS64 = `CSS_MS64_CYC,
   parameter int CK16K = `CSS_CK16K,
   parameter int CK32K = `CSS_CK32K
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic capture,
   input wire logic [3:0] clockSourceSelect,
   input wire logic [1:0] startupTimeSelect,
   input wire logic divideByEightConfig,
   output css_pkg::css_cfg_t cfg,
   output css_pkg::css_delay_t dly
);
   localparam logic [15:0] M4 = 16'(MS4);
   localparam logic [15:0] M64 = 16'(MS64);
   localparam logic [15:0] K1 = 16'(`CSS_CK1K);
   localparam logic [15:0] K16 = 16'(CK16K);
   localparam logic [15:0] K32 = 16'(CK32K);

   if (MS4 < 1 || MS64 < 1 || CK16K < 1 || CK32K < 1 || MS4 > 65535 || MS64 > 65535 ||
       CK16K > 65535 || CK32K > 65535) begin : g_bad_count
      $error("Decoded delay counts must lie between 1 and 65535");
   end

   function automatic css_pkg::css_delay_t decode(input logic [3:0] s, input logic [1:0] f);
      css_pkg::css_delay_t d;
      d = '0;
      case (s)
         `CSS_SRC_PLL: begin
            d.wakeCk = f[0] ? K16 : K1;
            d.wakeMs = f[1] ? M64 : M4;
            d.rstCk = `CSS_CK_RST;
            d.rstMs = M4;
         end
         `CSS_SRC_RC, `CSS_SRC_LP: begin
            d.wakeCk = `CSS_CK_WAKE_SHORT;
            d.rstCk = `CSS_CK_RST;
            d.rstMs = (f == 2'h0) ? 16'h0000 : ((f == 2'h1) ? M4 : M64);
         end
         `CSS_SRC_LFX: begin
            d.wakeCk = (f == 2'h2) ? K32 : K1;
            d.rstMs = (f == 2'h0) ? M4 : M64;
         end
         default: d = '0;
      endcase
      return d;
   endfunction : decode

   function automatic logic isBad(input logic [3:0] s, input logic [1:0] f);
      logic known;
      known = (s == `CSS_SRC_PLL) || (s == `CSS_SRC_RC) || (s == `CSS_SRC_LP) ||
              (s == `CSS_SRC_LFX);
      return !known || (s != `CSS_SRC_PLL && f == 2'h3);
   endfunction : isBad

   // Shipped settings stand until the first capture
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= '{src: `CSS_SHIP_SRC, startup_time_select: `CSS_SHIP_SUT, div8: `CSS_SHIP_DIV8, bad: 1'b0};
         dly <= '0;
      end else if (capture) begin
         cfg <= '{src: clockSourceSelect, startup_time_select: startupTimeSelect, div8: divideByEightConfig,
                  bad: isBad(clockSourceSelect, startupTimeSelect)};
         dly <= decode(clockSourceSelect, startupTimeSelect);
      end
   end
endmodule : css_cfg_latch

//--- hw/clock_source_startup_select.sv
// Clock source selection, start-up delay sequencing and calibration register
`include "css_consts.svh"
module clock_source_startup_select #(
   parameter int WDT_MS4_CYC = `CSS_MS4_CYC,
   parameter int WDT_MS64_CYC = `CSS_MS64_CYC,
   parameter int CK16K_CYC = `CSS_CK16K,
   parameter int CK32K_CYC = `CSS_CK32K
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [3:0] clockSourceSelect,
   input wire logic [1:0] startupTimeSelect,
   input wire logic divideByEightConfig,
   input wire logic [7:0] factoryTrim,
   input wire logic wdtTick,
   input wire logic srcTick,
   input wire logic sleepReq,
   input wire logic wakeReq,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output logic cpuRun,
   output logic [7:0] rcOscCalibration,
   output logic pllOn,
   output logic pllTimerClkEn,
   output logic [3:0] sysSrc,
   output logic sysPllDiv4,
   output logic sysDiv8,
   output logic configError
);
   if (WDT_MS4_CYC < 1 || WDT_MS64_CYC < 1 || CK16K_CYC < 1 || CK32K_CYC < 1 ||
       WDT_MS4_CYC > 65535 || WDT_MS64_CYC > 65535 || CK16K_CYC > 65535 ||
       CK32K_CYC > 65535) begin : g_bad_param
      $error("Delay counts must lie between 1 and 65535");
   end

   css_pkg::css_state_t state;
   css_pkg::css_state_t next_state;
   css_pkg::css_cfg_t cfg;
   css_pkg::css_delay_t dly;
   logic pllEnableBit;
   logic loadCnt;
   logic [15:0] loadMs;
   logic [15:0] loadCk;
   logic [15:0] msRemain;
   logic [15:0] ckRemain;
   logic msZero;
   logic ckZero;
   logic ckTick;
   logic rstArm;

   css_cfg_latch #(
      .MS4(WDT_MS4_CYC),
      .MS64(WDT_MS64_CYC),
      .CK16K(CK16K_CYC),
      .CK32K(CK32K_CYC)
   ) u_cfg (
      .mclk(mclk),
      .rst_b(rst_b),
      .capture(state == css_pkg::ST_BOOT),
      .clockSourceSelect(clockSourceSelect),
      .startupTimeSelect(startupTimeSelect),
      .divideByEightConfig(divideByEightConfig),
      .cfg(cfg),
      .dly(dly)
   );

   // Millisecond part always runs on the watchdog oscillator
   css_tick_counter #(.W(16)) u_ms (
      .mclk(mclk),
      .rst_b(rst_b),
      .load(loadCnt),
      .loadVal(loadMs),
      .tick(wdtTick),
      .remain(msRemain),
      .zero(msZero)
   );

   // Source cycles are counted once the real-time part has elapsed
   assign ckTick = srcTick && msZero;

   css_tick_counter #(.W(16)) u_ck (
      .mclk(mclk),
      .rst_b(rst_b),
      .load(loadCnt),
      .loadVal(loadCk),
      .tick(ckTick),
      .remain(ckRemain),
      .zero(ckZero)
   );

   always_comb begin
      next_state = state;
      loadCnt = 1'b0;
      loadMs = dly.rstMs;
      loadCk = dly.rstCk;
      case (state)
         css_pkg::ST_BOOT: begin
            next_state = css_pkg::ST_RST;
         end
         css_pkg::ST_RST: begin
            if (cfg.bad) begin
               next_state = css_pkg::ST_HALT;
            end else if (msZero && ckZero) begin
               next_state = css_pkg::ST_RUN;
            end
         end
         css_pkg::ST_RUN: begin
            if (sleepReq) begin
               next_state = css_pkg::ST_SLEEP;
            end
         end
         css_pkg::ST_SLEEP: begin
            if (wakeReq) begin
               loadCnt = 1'b1;
               loadMs = dly.wakeMs;
               loadCk = dly.wakeCk;
               next_state = css_pkg::ST_WAKE;
            end
         end
         css_pkg::ST_WAKE: begin
            if (msZero && ckZero) begin
               next_state = css_pkg::ST_RUN;
            end
         end
         css_pkg::ST_HALT: begin
            next_state = css_pkg::ST_HALT;
         end
         default: begin
            next_state = css_pkg::ST_BOOT;
         end
      endcase
      // Reset delay is armed in the cycle after the configuration is caught
      if (state == css_pkg::ST_BOOT) begin
         loadCnt = 1'b0;
      end
      // Reset delay is loaded once the decoded counts of the capture stand
      if (rstArm) begin
         loadCnt = 1'b1;
         loadMs = dly.rstMs;
         loadCk = dly.rstCk;
      end
   end

   // Second load path: reset delay armed on entry to ST_RST
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rstArm <= 1'b0;
      end else begin
         rstArm <= (state == css_pkg::ST_BOOT);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= css_pkg::ST_BOOT;
      end else if (rstArm) begin
         state <= css_pkg::ST_RST;
      end else begin
         state <= next_state;
      end
   end

   // Execution is allowed only in the running state
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cpuRun <= 1'b0;
      end else begin
         cpuRun <= (next_state == css_pkg::ST_RUN) && !rstArm;
      end
   end

   // Calibration register: factory trim after reset, software afterwards
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rcOscCalibration <= `CSS_CAL_RESET;
      end else if (state == css_pkg::ST_BOOT) begin
         rcOscCalibration <= factoryTrim;
      end else if (regWr && regAddr == `CSS_REG_CAL) begin
         rcOscCalibration <= regWrData;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pllEnableBit <= 1'b0;
      end else if (regWr && regAddr == `CSS_REG_PLL) begin
         pllEnableBit <= regWrData[`CSS_PLL_EN_BIT];
      end
   end

   // Clock path selection from the captured configuration and the PLL enable bit
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pllOn <= 1'b0;
         pllTimerClkEn <= 1'b0;
         sysSrc <= `CSS_SHIP_SRC;
         sysPllDiv4 <= 1'b0;
         sysDiv8 <= `CSS_SHIP_DIV8;
         configError <= 1'b0;
      end else begin
         pllOn <= pllEnableBit || (cfg.src == `CSS_SRC_PLL);
         pllTimerClkEn <= pllEnableBit || (cfg.src == `CSS_SRC_PLL);
         sysSrc <= cfg.src;
         sysPllDiv4 <= (cfg.src == `CSS_SRC_PLL);
         sysDiv8 <= cfg.div8;
         configError <= cfg.bad;
      end
   end

   // Read data stand in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `CSS_REG_CAL: regRdData <= rcOscCalibration;
            `CSS_REG_PLL: regRdData <= {6'h00, pllOn, pllEnableBit};
            `CSS_REG_STAT: regRdData <= {cpuRun, cfg.div8, cfg.startup_time_select, cfg.src};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   a_pll_enable_path: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (pllOn == $past(pllEnableBit || (cfg.src == `CSS_SRC_PLL))))
      else $error("PLL enable does not follow bit or source");

   a_pll_div_four: assert property (@(posedge mclk) disable iff (!rst_b)
      sysPllDiv4 |-> (sysSrc == `CSS_SRC_PLL))
      else $error("Divide by four without PLL source");

   a_trim_reset_load: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_BOOT) |=> (rcOscCalibration == $past(factoryTrim)))
      else $error("Factory trim not loaded");

   a_trim_sw_write: assert property (@(posedge mclk) disable iff (!rst_b)
      (regWr && regAddr == `CSS_REG_CAL && state != css_pkg::ST_BOOT)
      |=> (rcOscCalibration == $past(regWrData)))
      else $error("Calibration write lost");

   a_run_after_delay: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(cpuRun) |-> (msRemain == 16'h0000 && ckRemain == 16'h0000))
      else $error("Execution started before delay expired");

   a_wake_holds_cpu: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_WAKE && !ckZero) |-> ##1 !cpuRun)
      else $error("Running during wake delay");

   a_ms_wdt_only: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_RST && !rstArm && !wdtTick && !msZero)
      |=> (msRemain == $past(msRemain)))
      else $error("Millisecond count moved without watchdog tick");

   a_bad_cfg_halt: assert property (@(posedge mclk) disable iff (!rst_b)
      configError |-> ##[0:2] (!cpuRun && state == css_pkg::ST_HALT))
      else $error("Reserved setting did not halt");

   a_cfg_held: assert property (@(posedge mclk) disable iff (!rst_b)
      (state != css_pkg::ST_BOOT && $past(state) != css_pkg::ST_BOOT) |-> $stable(cfg))
      else $error("Configuration changed during operation");

   a_div8_follow: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (sysDiv8 == $past(cfg.div8)))
      else $error("Divide by eight not applied");

   a_rst_delay_load: assert property (@(posedge mclk) disable iff (!rst_b)
      rstArm |=> (msRemain == $past(dly.rstMs) && ckRemain == $past(dly.rstCk)))
      else $error("Reset delay not loaded");

   a_wake_delay_load: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_SLEEP && wakeReq)
      |=> (msRemain == $past(dly.wakeMs) && ckRemain == $past(dly.wakeCk)))
      else $error("Wake delay not loaded");

   a_ck_waits_ms: assert property (@(posedge mclk) disable iff (!rst_b)
      (!msZero && !loadCnt) |=> (ckRemain == $past(ckRemain)))
      else $error("Source cycles counted before millisecond part");

   a_sleep_stops_cpu: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_RUN && sleepReq) |=> !cpuRun)
      else $error("Execution continued after sleep request");

   a_halt_no_run: assert property (@(posedge mclk) disable iff (!rst_b)
      (state == css_pkg::ST_HALT) |-> !cpuRun)
      else $error("Execution allowed while halted");

   a_run_state_match: assert property (@(posedge mclk) disable iff (!rst_b)
      cpuRun == (state == css_pkg::ST_RUN))
      else $error("Execution flag out of step with state");

   a_timer_clk_path: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (pllTimerClkEn == $past(pllEnableBit || (cfg.src == `CSS_SRC_PLL))))
      else $error("Timer clock path does not follow PLL enable");

   a_src_follow: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (sysSrc == $past(cfg.src)))
      else $error("System source does not follow configuration");

   a_pll_div_src: assert property (@(posedge mclk) disable iff (!rst_b)
      (cfg.src == `CSS_SRC_PLL) |=> sysPllDiv4)
      else $error("PLL source without divide by four");

   a_cal_read: assert property (@(posedge mclk) disable iff (!rst_b)
      (regRd && regAddr == `CSS_REG_CAL) |=> (regRdData == $past(rcOscCalibration)))
      else $error("Calibration read back wrong");
endmodule : clock_source_startup_select

//--- bench/tb_clock_source_startup_select.sv
// Self-checking bench for the clock source and start-up delay selector
module tb_clock_source_startup_select;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst_b, divEight, wdtTick, srcTick, sleepReq, wakeReq, regWr, regRd;
   logic [3:0] srcSel, sysSrc;
   logic [1:0] sutSel, regAddr;
   logic [7:0] trim, regWrData, regRdData, rcOscCalibration;
   logic cpuRun, pllOn, pllTimerClkEn, sysPllDiv4, sysDiv8, configError;
   int mismatches = 0;
   int checksDone = 0;

   clock_source_startup_select #(.WDT_MS4_CYC(4), .WDT_MS64_CYC(8), .CK16K_CYC(16),
      .CK32K_CYC(32)) i_dut (.mclk(mclk), .rst_b(rst_b), .clockSourceSelect(srcSel),
      .startupTimeSelect(sutSel), .divideByEightConfig(divEight), .factoryTrim(trim),
      .wdtTick(wdtTick), .srcTick(srcTick), .sleepReq(sleepReq), .wakeReq(wakeReq),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .cpuRun(cpuRun), .rcOscCalibration(rcOscCalibration),
      .pllOn(pllOn), .pllTimerClkEn(pllTimerClkEn), .sysSrc(sysSrc),
      .sysPllDiv4(sysPllDiv4), .sysDiv8(sysDiv8), .configError(configError));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (mismatches == 0 && checksDone > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // Applies reset with a new configuration and releases it on a clock edge
   task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic d8);
      @(posedge mclk);
      rst_b <= 1'b0;
      srcSel <= s;
      sutSel <= t;
      divEight <= d8;
      trim <= {s, 2'h0, t} ^ 8'hA5;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
   endtask : boot

   // Counts edges until execution is allowed and checks the count window
   task automatic waitRun(input int lo, input int span);
      int n;
      n = 0;
      while (cpuRun !== 1'b1 && n < lo + span + 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (cpuRun !== 1'b1) begin
         chk({15'h0, cpuRun}, 16'h1);
         end_sim();
      end
      chk({15'h0, n >= lo && n <= lo + span}, 16'h1);
   endtask : waitRun

   task automatic pulse(input logic w);
      @(posedge mclk);
      if (w) begin
         wakeReq <= 1'b1;
      end else begin
         sleepReq <= 1'b1;
      end
      @(posedge mclk);
      wakeReq <= 1'b0;
      sleepReq <= 1'b0;
   endtask : pulse

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk({8'h0, regRdData}, {8'h0, exp});
   endtask : rd

   // Every legal source and start-up field: reset delay, then sleep and wake delay
   task automatic run_table();
      int rMs, rCk, wMs, wCk;
      for (int s = 1; s <= 4; s++) begin
         for (int t = 0; t < ((s == 1) ? 4 : 3); t++) begin
            boot(4'(s), 2'(t), 1'b1);
            if (s == 1) begin
               rMs = 4;
               rCk = 14;
               wMs = t[1] ? 8 : 4;
               wCk = t[0] ? 16 : 1024;
            end else if (s == 4) begin
               rMs = (t == 0) ? 4 : 8;
               rCk = 0;
               wMs = 0;
               wCk = (t == 2) ? 32 : 1024;
            end else begin
               rMs = (t == 0) ? 0 : ((t == 1) ? 4 : 8);
               rCk = 14;
               wMs = 0;
               wCk = 6;
            end
            waitRun(rMs + rCk + 1, 6);
            chk({12'h0, sysSrc}, 16'(s));
            chk({15'h0, sysPllDiv4}, 16'(s == 1));
            chk({15'h0, pllOn}, 16'(s == 1));
            chk({15'h0, pllTimerClkEn}, 16'(s == 1));
            chk({8'h0, rcOscCalibration}, {8'h0, trim});
            chk({15'h0, configError}, 16'h0);
            pulse(1'b0);
            @(posedge mclk);
            #1;
            chk({15'h0, cpuRun}, 16'h0);
            pulse(1'b1);
            waitRun(wMs + wCk, 4);
         end
      end
   endtask : run_table

   // Reserved start-up fields and an unsupported source must not start execution
   task automatic bad_cfg();
      logic [5:0] cfgs [4];
      cfgs = '{6'h0B, 6'h0F, 6'h13, 6'h14};
      for (int i = 0; i < 4; i++) begin
         boot(cfgs[i][5:2], cfgs[i][1:0], 1'b1);
         repeat (40) @(posedge mclk);
         #1;
         chk({15'h0, configError}, 16'h1);
         chk({15'h0, cpuRun}, 16'h0);
      end
   endtask : bad_cfg

   task automatic reg_access();
      boot(4'h2, 2'h0, 1'b0);
      waitRun(15, 6);
      chk({15'h0, sysDiv8}, 16'h0);
      rd(2'h2, 8'h82);
      wr(2'h0, 8'h5A);
      #1;
      chk({8'h0, rcOscCalibration}, 16'h005A);
      rd(2'h0, 8'h5A);
      rd(2'h1, 8'h00);
      wr(2'h1, 8'h01);
      @(posedge mclk);
      #1;
      chk({15'h0, pllOn}, 16'h1);
      chk({15'h0, pllTimerClkEn}, 16'h1);
      rd(2'h1, 8'h03);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'hFF);
      rd(2'h2, 8'h82);
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h00);
      @(posedge mclk);
      srcSel <= 4'h1;
      sutSel <= 2'h3;
      divEight <= 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      chk({12'h0, sysSrc}, 16'h2);
      chk({15'h0, pllOn}, 16'h0);
      rd(2'h2, 8'h82);
   endtask : reg_access

   // Without watchdog ticks the millisecond part, and so the start-up, must stall
   task automatic wdt_gap();
      boot(4'h2, 2'h1, 1'b0);
      wdtTick <= 1'b0;
      repeat (10) @(posedge mclk);
      wdtTick <= 1'b1;
      #1;
      chk({15'h0, cpuRun}, 16'h0);
      waitRun(19, 2);
   endtask : wdt_gap

   initial begin
      rst_b = 1'b0;
      srcSel = 4'h1;
      sutSel = 2'h0;
      divEight = 1'b0;
      trim = 8'h3C;
      wdtTick = 1'b1;
      srcTick = 1'b1;
      sleepReq = 1'b0;
      wakeReq = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 2'h0;
      regWrData = 8'h00;
      repeat (20) @(posedge mclk);
      #1;
      chk({12'h0, sysSrc}, 16'h2);
      chk({15'h0, sysDiv8}, 16'h1);
      chk({15'h0, cpuRun}, 16'h0);
      run_table();
      bad_cfg();
      reg_access();
      wdt_gap();
      end_sim();
   end
endmodule : tb_clock_source_startup_select
